// >>> hw/tcc_timer.sv
// The AHB-Lite slave port and the register offsets were left to the implementer.
`default_nettype none
// Notes on behaviour
// - Capture mode: reaching reload interrupts, keeps counting.
// - Capture edge selectable rising or falling.
// - Capture stores count; reload leaves holding untouched.
// - Count advances once per prescale period.
// - Compare mode counts toward reload register value.
// - Compare mode counts system clock, not pin.
// - Compare match interrupts without reloading count.
// - Compare match toggles output when enabled.
// - Compare mode wraps FFFFH to 0000H.
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int PRE_W = TCC_CTRL_PRE_W
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Timer pins.
    input  wire logic        timer_in,
    output logic             timer_out,
    // Interrupt.
    output logic             irq
);
    tcc_ev_if evp ();

    // Register state.
    logic              en_r, en_nxt;
    tcc_mode_t         mode_r, mode_nxt;
    logic              edge_r, edge_nxt;
    logic              outen_r, outen_nxt;
    logic [PRE_W-1:0]  pre_r, pre_nxt;
    logic [15:0]       count_r, count_nxt;
    logic [15:0]       reload_r, reload_nxt;
    logic [15:0]       hold_r, hold_nxt;
    logic [TCC_NUM_EV-1:0] ien_r, ien_nxt;
    logic              tout_r, tout_nxt;
    logic              pin_d_r;
    logic              irq_nxt;
    // Bus state.
    logic              wr_pend_r, wr_pend_nxt;
    logic [7:0]        addr_r, addr_nxt;
    logic [31:0]       rdata_nxt;
    logic              tick;
    logic              cap_edge;
    logic [TCC_NUM_EV-1:0] ev;
    logic [TCC_NUM_EV-1:0] clr;
    logic              wr_now;

    // Prescaled tick for counting.
    // prescale period tick
    tcc_prescaler #(.PW(PRE_W)) u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (en_r),
        .pre     (pre_r),
        .tick    (tick)
    );

    tcc_irq u_irq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .evp     (evp)
    );

    // Capture edge detection on the timer input pin.
    // selectable capture edge
    assign cap_edge = (edge_r == 1'b0) ? (timer_in & ~pin_d_r) : (~timer_in & pin_d_r);

    // A write is completed in the data phase after its address phase.
    assign wr_now = wr_pend_r;

    // Bus address phase capture and read data.
    always_comb begin
        wr_pend_nxt = 1'b0;
        addr_nxt    = addr_r;
        rdata_nxt   = 32'h0000_0000;
        if (hsel && hready && htrans[1]) begin
            addr_nxt    = {haddr[7:2], 2'b00};
            wr_pend_nxt = hwrite;
            if (!hwrite) begin
                unique case ({haddr[7:2], 2'b00})
                    TCC_OFF_CTRL: begin
                        rdata_nxt[TCC_CTRL_EN_BIT]    = en_r;
                        rdata_nxt[TCC_CTRL_MODE_BIT]  = mode_r;
                        rdata_nxt[TCC_CTRL_EDGE_BIT]  = edge_r;
                        rdata_nxt[TCC_CTRL_OUTEN_BIT] = outen_r;
                        rdata_nxt[TCC_CTRL_PRE_LSB +: PRE_W] = pre_r;
                    end
                    TCC_OFF_COUNT:  rdata_nxt[15:0] = count_r;
                    TCC_OFF_RELOAD: rdata_nxt[15:0] = reload_r;
                    TCC_OFF_HOLD:   rdata_nxt[15:0] = hold_r;
                    TCC_OFF_STAT:   rdata_nxt[TCC_NUM_EV-1:0] = evp.stat;
                    TCC_OFF_IEN:    rdata_nxt[TCC_NUM_EV-1:0] = ien_r;
                    default:        rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register writes, counting, capture and compare.
    always_comb begin
        en_nxt     = en_r;
        mode_nxt   = mode_r;
        edge_nxt   = edge_r;
        outen_nxt  = outen_r;
        pre_nxt    = pre_r;
        count_nxt  = count_r;
        reload_nxt = reload_r;
        hold_nxt   = hold_r;
        ien_nxt    = ien_r;
        tout_nxt   = tout_r;
        ev         = '0;
        clr        = '0;
        // Counting; the counter stands still while disabled.
        // hold while disabled
        if (en_r) begin
            if (tick) begin
                count_nxt = count_r + 16'h0001;
                if (count_r == reload_r) begin
                    if (mode_r == TCC_MODE_CAPTURE) begin
                        ev[TCC_ST_RELOAD_BIT] = 1'b1;
                    end else begin
                        ev[TCC_ST_CMP_BIT] = 1'b1;
                        if (outen_r) begin
                            tout_nxt = ~tout_r;
                        end
                    end
                end
            end
            if (mode_r == TCC_MODE_CAPTURE && cap_edge) begin
                hold_nxt = count_r;
                ev[TCC_ST_CAPT_BIT] = 1'b1;
            end
        end
        // Software writes, except an ICLR clear, take priority over the counting path.
        // software loads configuration
        if (wr_now) begin
            unique case (addr_r)
                TCC_OFF_CTRL: begin
                    en_nxt    = hwdata[TCC_CTRL_EN_BIT];
                    mode_nxt  = tcc_mode_t'(hwdata[TCC_CTRL_MODE_BIT]);
                    edge_nxt  = hwdata[TCC_CTRL_EDGE_BIT];
                    outen_nxt = hwdata[TCC_CTRL_OUTEN_BIT];
                    pre_nxt   = hwdata[TCC_CTRL_PRE_LSB +: PRE_W];
                end
                TCC_OFF_COUNT:  count_nxt  = hwdata[15:0];
                TCC_OFF_RELOAD: reload_nxt = hwdata[15:0];
                TCC_OFF_HOLD:   hold_nxt   = hwdata[15:0];
                TCC_OFF_IEN:    ien_nxt    = hwdata[TCC_NUM_EV-1:0];
                TCC_OFF_ICLR:   clr        = hwdata[TCC_NUM_EV-1:0];
                default: begin
                end
            endcase
        end
    end

    assign evp.ev  = ev;
    assign evp.clr = clr;

    // Interrupt level from enabled sticky bits after this cycle's update.
    always_comb begin
        irq_nxt = |(((evp.stat & ~clr) | ev) & ien_nxt);
    end

    // State registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r      <= 1'b0;
            mode_r    <= TCC_MODE_CAPTURE;
            edge_r    <= 1'b0;
            outen_r   <= 1'b0;
            pre_r     <= PRE_W'(TCC_PRE_RST);
            count_r   <= TCC_COUNT_RST;
            reload_r  <= TCC_RELOAD_RST;
            hold_r    <= TCC_HOLD_RST;
            ien_r     <= '0;
            tout_r    <= 1'b0;
            pin_d_r   <= 1'b0;
            irq       <= 1'b0;
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hrdata    <= 32'h0000_0000;
        end else begin
            en_r      <= en_nxt;
            mode_r    <= mode_nxt;
            edge_r    <= edge_nxt;
            outen_r   <= outen_nxt;
            pre_r     <= pre_nxt;
            count_r   <= count_nxt;
            reload_r  <= reload_nxt;
            hold_r    <= hold_nxt;
            ien_r     <= ien_nxt;
            tout_r    <= tout_nxt;
            pin_d_r   <= timer_in;
            irq       <= irq_nxt;
            wr_pend_r <= wr_pend_nxt;
            addr_r    <= addr_nxt;
            hrdata    <= rdata_nxt;
        end
    end

    // Zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign timer_out = tout_r;
endmodule : tcc_timer
`default_nettype wire

// >>> hw/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
    // Register byte addresses.
    localparam logic [7:0] TCC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] TCC_OFF_COUNT  = 8'h04;
    localparam logic [7:0] TCC_OFF_RELOAD = 8'h08;
    localparam logic [7:0] TCC_OFF_HOLD   = 8'h0c;
    localparam logic [7:0] TCC_OFF_STAT   = 8'h10;
    localparam logic [7:0] TCC_OFF_IEN    = 8'h14;
    localparam logic [7:0] TCC_OFF_ICLR   = 8'h18;
    // Control register fields.
    localparam int TCC_CTRL_EN_BIT    = 0;
    localparam int TCC_CTRL_MODE_BIT  = 1;
    localparam int TCC_CTRL_EDGE_BIT  = 2;
    localparam int TCC_CTRL_OUTEN_BIT = 3;
    localparam int TCC_CTRL_PRE_LSB   = 8;
    localparam int TCC_CTRL_PRE_W     = 8;
    // Status register fields.
    localparam int TCC_ST_RELOAD_BIT  = 0;
    localparam int TCC_ST_CAPT_BIT    = 1;
    localparam int TCC_ST_CMP_BIT     = 2;
    localparam int TCC_NUM_EV         = 3;
    // Reset values.
    localparam logic [15:0] TCC_COUNT_RST  = 16'h0001;
    localparam logic [15:0] TCC_RELOAD_RST = 16'hffff;
    localparam logic [15:0] TCC_HOLD_RST   = 16'h0000;
    localparam logic [7:0]  TCC_PRE_RST    = 8'h00;
    // Modes.
    typedef enum logic {TCC_MODE_CAPTURE = 1'b0, TCC_MODE_COMPARE = 1'b1} tcc_mode_t;
    // Bus transfer type codes.
    localparam logic [1:0] TCC_HTRANS_NONSEQ = 2'b10;
endpackage : tcc_pkg
`default_nettype wire

// >>> hw/tcc_ev_if.sv
`default_nettype none
interface tcc_ev_if;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [2:0] stat;
    modport core (output ev, input stat);
    modport irq (input ev, input clr, output stat);
endinterface : tcc_ev_if
`default_nettype wire

// >>> hw/tcc_prescaler.sv
`default_nettype none
module tcc_prescaler
    import tcc_pkg::*;
#(
    parameter int PW = 8
) (
    // Clock and reset.
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // Control.
    input  wire logic          run,
    input  wire logic [PW-1:0] pre,
    // Tick out, one cycle every pre+1 clocks.
    output logic               tick
);
    logic [PW-1:0] cnt_r;
    logic [PW-1:0] cnt_nxt;
    logic          tick_nxt;

    // Count clocks and fire a tick when the period completes.
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!run) begin
            cnt_nxt = '0;
        end else if (cnt_r >= pre) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // Register the divider state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule : tcc_prescaler
`default_nettype wire

// >>> hw/tcc_irq.sv
`default_nettype none
module tcc_irq
    import tcc_pkg::*;
(
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Event path.
    tcc_ev_if.irq     evp
);
    logic [TCC_NUM_EV-1:0] stat_r;
    logic [TCC_NUM_EV-1:0] stat_nxt;

    // Sticky bits: a new event wins over a clear in the same cycle.
    always_comb begin
        stat_nxt = (stat_r & ~evp.clr) | evp.ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign evp.stat = stat_r;
endmodule : tcc_irq
`default_nettype wire

// >>> dv/tcc_props.sv
`default_nettype none
module tcc_props
    import tcc_pkg::*;
(
    // Bus side.
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pin and interrupt.
    input wire logic        timer_out,
    input wire logic        irq
);
    logic       dv_r;
    logic       dw_r;
    logic [7:0] da_r;
    logic [3:0] ctl_r;
    logic [2:0] ien_r;
    // Shadow the address phase and the written settings.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv_r  <= 1'b0;
            dw_r  <= 1'b0;
            da_r  <= 8'h00;
            ctl_r <= 4'h0;
            ien_r <= 3'h0;
        end else begin
            dv_r <= hsel & hready & htrans[1];
            dw_r <= hwrite;
            da_r <= haddr[7:0];
            if (dv_r && dw_r && da_r == TCC_OFF_CTRL) begin
                ctl_r <= hwdata[3:0];
            end
            if (dv_r && dw_r && da_r == TCC_OFF_IEN) begin
                ien_r <= hwdata[2:0];
            end
        end
    end
    // A read data phase and the toggle-enabling setup.
    wire logic rd  = dv_r & ~dw_r;
    wire logic cfg = ctl_r[0] & ctl_r[1] & ctl_r[3];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_off3;
        !ctl_r[0] [*3];
    endsequence
    sequence s_noien;
        (ien_r == 3'h0) [*3];
    endsequence
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_idle_rdata: assert property (!rd |-> hrdata == 32'h0)
        else $error("read data outside a data phase");
    a_hold_upper: assert property (rd && da_r == TCC_OFF_HOLD |-> hrdata[31:16] == 16'h0)
        else $error("capture value wider than 16 bits");
    a_count_upper: assert property (rd && da_r == TCC_OFF_COUNT |-> hrdata[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    a_reload_upper: assert property (rd && da_r == TCC_OFF_RELOAD |-> hrdata[31:16] == 16'h0)
        else $error("compare value wider than 16 bits");
    a_out_disabled: assert property (s_off3 |-> $stable(timer_out))
        else $error("output pin moved while disabled");
    a_out_cause: assert property (!$stable(timer_out) |-> $past(cfg) || $past(cfg, 2))
        else $error("output pin moved without compare setup");
    a_irq_noien: assert property (s_noien |-> !irq)
        else $error("interrupt with no source enabled");
endmodule : tcc_props
bind tcc_timer tcc_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_out(timer_out), .irq(irq));
`default_nettype wire

// >>> dv/tcc_pin_model.sv
`default_nettype none
module tcc_pin_model (
    // Clock and requested input level.
    input  wire logic hclk,
    input  wire logic lvl,
    // Pins.
    output logic      timer_in,
    input  wire logic timer_out,
    // Count of output pin changes.
    output logic [7:0] flips
);
    logic last_r = 1'b0;
    initial timer_in = 1'b0;
    initial flips = 8'h00;
    // Drive the input pin after each edge and count output changes.
    // Only a known level turning into the other known level counts, so the
    // unknown pin level before the first reset edge adds no false change.
    always @(posedge hclk) begin
        timer_in <= lvl;
        last_r   <= timer_out;
        if ((last_r === 1'b0 && timer_out === 1'b1) ||
            (last_r === 1'b1 && timer_out === 1'b0)) begin
            flips <= flips + 8'h01;
        end
    end
endmodule : tcc_pin_model
`default_nettype wire

// >>> dv/tcc_timer_tb.sv
`default_nettype none
module tcc_timer_tb
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        lvl = 1'b0;
    logic [31:0] hrdata, rq;
    logic        hready, hresp, timer_in, timer_out, irq, rdy_q;
    logic [7:0]  flips;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    always #10 hclk = ~hclk;
    // Keep the bus answers seen at each rising edge.
    always @(posedge hclk) begin
        rq    <= hrdata;
        rdy_q <= hready;
        cyc   <= cyc + 1;
    end
    tcc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .timer_in(timer_in), .timer_out(timer_out),
        .irq(irq));
    tcc_pin_model pins (.hclk(hclk), .lvl(lvl), .timer_in(timer_in), .timer_out(timer_out),
        .flips(flips));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : step
    task automatic rdy;
        int n;
        n = 0;
        do begin
            step(1);
            n++;
        end while (rdy_q !== 1'b1 && n < 20);
        if (rdy_q !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask : rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= TCC_HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        r = rq;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic test_reset;
        logic [7:0]  a[8] = '{TCC_OFF_CTRL, TCC_OFF_COUNT, TCC_OFF_RELOAD, TCC_OFF_HOLD,
                              TCC_OFF_STAT, TCC_OFF_IEN, TCC_OFF_ICLR, 8'h1c};
        logic [31:0] e[8] = '{32'h0, {16'h0, TCC_COUNT_RST}, {16'h0, TCC_RELOAD_RST},
                              {16'h0, TCC_HOLD_RST}, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] v;
        wr(8'h1c, 32'hffffffff);
        wr(TCC_OFF_STAT, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            rd(a[i], v);
            chk(v, e[i]);
        end
        $display("test_reset done");
    endtask : test_reset
    task automatic test_compare;
        logic [31:0] v, c;
        wr(TCC_OFF_CTRL, 32'h0);
        wr(TCC_OFF_COUNT, 32'h0000fffd);
        wr(TCC_OFF_RELOAD, 32'h00000002);
        wr(TCC_OFF_IEN, 32'h4);
        wr(TCC_OFF_CTRL, 32'h0000000b);
        step(30);
        chk(flips, 8'h1);
        chk(irq, 1'b1);
        rd(TCC_OFF_STAT, v);
        chk(v, 32'h4);
        wr(TCC_OFF_CTRL, 32'h0000000a);
        rd(TCC_OFF_COUNT, c);
        chk(c > 32'h3 && c < 32'h30, 1'b1);
        step(5);
        rd(TCC_OFF_COUNT, v);
        chk(v, c);
        chk(flips, 8'h1);
        wr(TCC_OFF_ICLR, 32'h4);
        step(2);
        chk(irq, 1'b0);
        $display("test_compare done");
    endtask : test_compare
    task automatic test_capture;
        logic [31:0] v, k;
        int          t0, t;
        for (int e = 0; e < 2; e++) begin
            k = {16'h0, 8'h03, 5'h0, e[0], 2'b00};
            lvl <= (e == 0);
            wr(TCC_OFF_CTRL, k);
            wr(TCC_OFF_COUNT, 32'h1);
            wr(TCC_OFF_RELOAD, 32'h8);
            wr(TCC_OFF_HOLD, 32'h0);
            wr(TCC_OFF_ICLR, 32'h7);
            wr(TCC_OFF_IEN, 32'h3);
            wr(TCC_OFF_CTRL, k | 32'h1);
            t0 = cyc;
            lvl <= (e != 0);
            step(60);
            rd(TCC_OFF_HOLD, v);
            chk(v, 32'h0);
            rd(TCC_OFF_STAT, v);
            chk(v, 32'h1);
            t = cyc;
            lvl <= (e == 0);
            step(6);
            rd(TCC_OFF_HOLD, v);
            chk(v + 2 >= (t - t0) / 4 && v <= (t - t0) / 4 + 3, 1'b1);
            rd(TCC_OFF_STAT, v);
            chk(v, 32'h3);
            rd(TCC_OFF_COUNT, v);
            chk(v > 32'h8, 1'b1);
            chk(irq, 1'b1);
            chk(flips, 8'h1);
        end
        $display("test_capture done");
    endtask : test_capture
    // Reset for six cycles, then run each test.
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        step(1);
        test_reset();
        test_compare();
        test_capture();
        complete_run();
    end
endmodule : tcc_timer_tb
`default_nettype wire
